// >>> analog_side.sv
/*
  Far side of the sequencer: channel levels, comparator and port pins.
  Assumes pull-ups on every pin and a comparator that settles in one cycle.
*/
`timescale 1ns/100ps
`default_nettype none
module analog_side
  import sar_adc_pkg::*;
(
  input wire logic i_sys_clk, // Clock
  input wire logic [4:0] i_chan, // Channel
  input wire logic i_power, // Powered
  input wire logic [7:0] i_trial, // Trial code
  input wire logic [7:0] i_offset, // Level shift
  input wire logic [15:0] i_drive, // Pin values
  input wire logic [15:0] i_drive_oe_n, // Low drives
  output logic o_above, // Comparator
  output logic [15:0] o_level // Pin levels
);
  logic [7:0] level;
  logic noise_d;
  logic noise_q = 1'b0;
  always_comb begin
    level = 8'(i_chan) * 8'h11 + i_offset;
    noise_d = ~noise_q;
    o_above = level >= i_trial;
    if (i_chan == CHAN_VREF_HIGH) begin
      o_above = 1'b1;
    end else if (i_chan == CHAN_VREF_LOW) begin
      o_above = i_trial == 8'h00;
    end else if (!i_power || i_chan >= 5'h0F) begin
      o_above = noise_q;
    end
  end
  // Toggles so a stale answer never looks valid
  always_ff @(posedge i_sys_clk) begin
    noise_q <= noise_d;
  end
  // Undriven pins float high
  assign o_level = (i_drive & ~i_drive_oe_n) | i_drive_oe_n;
endmodule : analog_side
`default_nettype wire

// >>> sar_adc_assertions.sv
/*
  Checker of the sequencer's port behaviour, bound to its top module.
  Assumes one clock domain and the package's register offsets.
*/
`timescale 1ns/100ps
`default_nettype none
module sar_adc_checker
  import sar_adc_pkg::*;
#(
  parameter int PIN_W = 8
) (
  input wire logic i_sys_clk, // Clock
  input wire logic i_rst, // Reset
  input wire logic i_stop_mode, // Stop
  input wire logic i_wait_mode, // Wait
  input wire logic [7:0] i_wb_adr, // Address
  input wire logic [3:0] i_wb_sel, // Selects
  input wire logic i_wb_we, // Write
  input wire logic i_wb_cyc, // Cycle
  input wire logic i_wb_stb, // Strobe
  input wire logic [31:0] o_wb_dat, // Read data
  input wire logic o_wb_ack, // Ack
  input wire logic [2*PIN_W-1:0] o_pin_oe_n, // Pin enables
  input wire logic [4:0] o_mux_sel, // Channel
  input wire logic o_power_on, // Powered
  input wire logic [7:0] o_trial_code, // Trial code
  input wire logic o_irq, // Interrupt
  input wire logic o_wake // Wake
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);
  logic take;
  logic clr;
  // Requests taken, and the accesses that clear the interrupt
  assign take = i_wb_cyc && i_wb_stb && !o_wb_ack;
  assign clr = take && (i_wb_we ? i_wb_sel[0] && i_wb_adr == ADDR_STATUS_CONTROL : i_wb_adr == ADDR_RESULT);
  a_ack_after_take: assert property (take |=> o_wb_ack)
    else $error("request not acknowledged");
  a_ack_one_pulse: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack longer than one cycle");
  a_read_upper_zero: assert property (o_wb_ack |-> o_wb_dat[31:8] == 24'h0)
    else $error("read data wider than a byte");
  a_power_off_code: assert property (o_power_on == (o_mux_sel != CHAN_POWER_OFF))
    else $error("power state disagrees with channel");
  a_off_no_steps: assert property (!o_power_on ##1 !o_power_on |-> $stable(o_trial_code))
    else $error("conversion stepping while off");
  a_sel_pin_input: assert property (o_mux_sel < 5'h0F && $stable(o_mux_sel) |-> o_pin_oe_n[o_mux_sel[3:0]])
    else $error("selected pin driven");
  a_reset_values: assert property ($fell(i_rst) |-> o_mux_sel == CHAN_RESET && !o_irq && !o_power_on)
    else $error("wrong state after reset");
  a_irq_cleared: assert property (clr |=> !o_irq)
    else $error("interrupt not cleared");
  a_stop_no_irq: assert property ($rose(o_irq) |-> !$past(i_stop_mode))
    else $error("completion during stop");
  a_wake_in_wait: assert property (i_wait_mode && o_irq |-> ##[0:1] o_wake)
    else $error("no wake on interrupt");
endmodule : sar_adc_checker
bind sar_adc_sequencer sar_adc_checker #(.PIN_W(PIN_W)) sar_adc_checker_inst (.i_sys_clk, .i_rst,
  .i_stop_mode, .i_wait_mode, .i_wb_adr, .i_wb_sel, .i_wb_we, .i_wb_cyc, .i_wb_stb, .o_wb_dat,
  .o_wb_ack, .o_pin_oe_n, .o_mux_sel, .o_power_on, .o_trial_code, .o_irq, .o_wake);
`default_nettype wire

// >>> sar_adc_pkg.sv
/*
  Package for the successive-approximation converter sequencer.
  Holds register offsets, field positions, reset values and timing counts.
  Assumes an 8-bit register space reached over classic Wishbone, one word per register.
*/
package sar_adc_pkg;
  // Byte addresses of the registers
  localparam logic [7:0] ADDR_STATUS_CONTROL = 8'h38;
  localparam logic [7:0] ADDR_RESULT = 8'h39;
  localparam logic [7:0] ADDR_CLOCK_CONTROL = 8'h3A;
  localparam logic [7:0] ADDR_PORT_DATA = 8'h3C;
  localparam logic [7:0] ADDR_PORT_DIR = 8'h3D;
  localparam logic [7:0] ADDR_PORT_PINS = 8'h3E;
  localparam logic [7:0] ADDR_PORT_DATA_HI = 8'h40;
  localparam logic [7:0] ADDR_PORT_DIR_HI = 8'h41;
  localparam logic [7:0] ADDR_PORT_PINS_HI = 8'h42;
  // Status and control fields
  localparam int DONE_BIT = 7;
  localparam int IRQ_EN_BIT = 6;
  localparam int CONT_BIT = 5;
  localparam int CHAN_LSB = 0;
  localparam int CHAN_W = 5;
  // Clock control fields
  localparam int PRESCALE_LSB = 5;
  localparam int SRC_BIT = 4;
  // Reset values, power-off code and channel count
  localparam logic [4:0] CHAN_RESET = 5'h1F;
  localparam logic [4:0] CHAN_POWER_OFF = 5'h1F;
  localparam logic [2:0] PRESCALE_RESET = 3'h0;
  localparam int NUM_CHANNELS = 15;
  // Conversion length in converter clock cycles
  localparam int CONV_CYCLES = 17;
  localparam logic [4:0] CONV_CYCLES_W = 5'h11;
  // Codes selecting the internal references
  localparam logic [4:0] CHAN_VREF_HIGH = 5'h1D;
  localparam logic [4:0] CHAN_VREF_LOW = 5'h1E;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CONV = 3'b010,
    ST_DONE = 3'b100
  } conv_state_t;
endpackage : sar_adc_pkg

// >>> sar_adc_sequencer.sv
/*
  Sequencer of an 8-bit successive-approximation converter with 15-input mux,
  port pin takeover, single and continuous modes, done flag and interrupt.
  Assumes an external comparator answering whether the input is at or above the trial code,
  pin inputs from outside the clock domain, and clock source enables on i_sys_clk.
*/
// Design decision made here: the Wishbone register port.
`timescale 1ns/100ps
`default_nettype none
// What this block does
// R1 - Each conversion yields an 8-bit result stored at completion.
// R2 - Five-bit channel field routes one of fifteen inputs to converter.
// R3 - Selected pin forced to input; port writes cannot drive it.
// R4 - Taken pin reads zero if direction 0, else data latch value.
// R5 - Status register write starts conversion lasting 16 to 17 converter clocks.
// R6 - High reference gives FF, ground gives 00, linear between.
// R7 - Continuous mode overwrites result whether read or not.
// R8 - Continuous bit repeats conversions; clear means one per start.
// R9 - Continuous mode keeps done flag set until status write or result read.
// R10 - Without interrupt enable, done flag read-only, cleared by write or read.
// R11 - With interrupt enable, done bit becomes writable and stops flagging completion.
// R12 - Interrupt raised per completion, cleared by result read or status write.
// R13 - Reset clears done, enable, continuous; channel bits all ones.
// R14 - All-ones channel code powers off converter; no conversion.
// R15 - Software waits one conversion after leaving power-off.
// R16 - Converter keeps running in wait mode; interrupt can wake.
// R17 - Stop mode aborts conversion; conversions resume afterwards; here none starts again until the next status write.
// R18 - Software waits one conversion after stop exit.
// R19 - Prescale divides by 1, 2, 4, 8, or 16 when top bit set.
// R20 - Source bit one selects bus clock, zero oscillator; reset oscillator.
// R21 - Unused channel codes give an undefined result.
// R22 - Status write mid-conversion abandons it and restarts with new settings.
// R23 - Result resolved one bit per step, most significant first.
module sar_adc_sequencer
  import sar_adc_pkg::*;
#(
  parameter int PIN_W = 8
) (
  input wire logic i_sys_clk, // System clock, 20 MHz
  input wire logic i_rst, // Async reset, active high
  input wire logic i_bus_tick, // Bus clock enable pulse
  input wire logic i_osc_tick, // Oscillator clock enable pulse
  input wire logic i_stop_mode, // Processor in stop mode
  input wire logic i_wait_mode, // Processor in wait mode
  input wire logic i_cmp_above, // Comparator: input at or above trial code
  input wire logic [7:0] i_wb_adr, // Wishbone address
  input wire logic [31:0] i_wb_dat, // Wishbone write data
  input wire logic [3:0] i_wb_sel, // Wishbone byte selects
  input wire logic i_wb_we, // Wishbone write enable
  input wire logic i_wb_cyc, // Wishbone cycle
  input wire logic i_wb_stb, // Wishbone strobe
  input wire logic [2*PIN_W-1:0] i_pin, // Pin levels, low port then high port
  output logic [31:0] o_wb_dat, // Wishbone read data
  output logic o_wb_ack, // Wishbone acknowledge
  output logic [2*PIN_W-1:0] o_pin, // Pin drive values
  output logic [2*PIN_W-1:0] o_pin_oe_n, // Pin output enable, low drives
  output logic [4:0] o_mux_sel, // Analog mux channel
  output logic o_power_on, // Analog section powered
  output logic [7:0] o_trial_code, // Trial code to comparator DAC
  output logic o_irq, // Conversion interrupt request
  output logic o_wake // Wake request in wait mode
);
  // Decode a channel code into a one-hot pin mask; non-pin codes give zero
  function automatic logic [2*PIN_W-1:0] chan_mask(input logic [4:0] ch);
    logic [2*PIN_W-1:0] m;
    m = '0;
    if (ch < 5'(NUM_CHANNELS)) begin
      m[ch[3:0]] = 1'b1;
    end
    return m;
  endfunction : chan_mask

  logic [2*PIN_W-1:0] pin_s1_q, pin_s2_q;
  logic bus_wr, bus_rd;
  logic wr_scr, rd_res;
  logic conv_tick;
  logic restart;

  // Register state
  logic done_q, done_d;
  logic irq_en_q, irq_en_d;
  logic cont_q, cont_d;
  logic [4:0] chan_q, chan_d;
  logic [2:0] prescale_q, prescale_d;
  logic src_bus_q, src_bus_d;
  logic [7:0] result_q, result_d;
  logic [2*PIN_W-1:0] pdata_q, pdata_d, pdir_q, pdir_d;
  logic irq_q, irq_d;
  logic ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  // Conversion state
  conv_state_t st_q, st_d;
  logic [4:0] cyc_q, cyc_d;
  logic [7:0] sar_q, sar_d;
  logic [2:0] bit_q, bit_d;
  logic [2*PIN_W-1:0] pin_o_q, pin_o_d, oe_n_q, oe_n_d;
  logic wake_q, wake_d, power_q;
  logic finish;
  logic [2*PIN_W-1:0] taken;
  logic [2*PIN_W-1:0] pin_read;

  // Pins come from outside; two stages before use
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end else begin
      pin_s1_q <= i_pin;
      pin_s2_q <= pin_s1_q;
    end
  end

  // Bus decode; one access per cycle, ack masks the repeat
  assign bus_wr = i_wb_cyc & i_wb_stb & i_wb_we & ~ack_q & i_wb_sel[0];
  assign bus_rd = i_wb_cyc & i_wb_stb & ~i_wb_we & ~ack_q;
  assign wr_scr = bus_wr & (i_wb_adr == ADDR_STATUS_CONTROL);
  assign rd_res = bus_rd & (i_wb_adr == ADDR_RESULT);
  // R22 status write restarts the prescaler phase
  assign restart = wr_scr | i_stop_mode;

  // R20 clock source and R19 divider
  sar_prescaler u_prescaler (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_bus_tick(i_bus_tick),
    .i_osc_tick(i_osc_tick),
    .i_src_bus(src_bus_q),
    .i_prescale(prescale_q),
    .i_restart(restart),
    .o_tick(conv_tick)
  );

  // R3 pin taken by the converter
  assign taken = chan_mask(chan_q);
  // R4 taken pin reads zero or latch
  always_comb begin
    for (int i = 0; i < 2*PIN_W; i++) begin
      if (taken[i]) begin
        pin_read[i] = pdir_q[i] & pdata_q[i];
      end else begin
        pin_read[i] = pdir_q[i] ? pdata_q[i] : pin_s2_q[i];
      end
    end
  end

  // Conversion sequencer next state
  always_comb begin
    st_d = st_q;
    cyc_d = cyc_q;
    sar_d = sar_q;
    bit_d = bit_q;
    finish = 1'b0;
    unique case (st_q)
      ST_IDLE: begin
      end
      ST_CONV: begin
        if (conv_tick) begin
          cyc_d = cyc_q + 5'h1;
          // R23 one bit per tick, top first
          if (cyc_q < 5'h8) begin
            if (!i_cmp_above) begin
              sar_d[bit_q] = 1'b0;
            end
            if (bit_q != 3'h0) begin
              sar_d[bit_q - 3'h1] = 1'b1;
            end
            bit_d = bit_q - 3'h1;
          end
          // R5 done on the seventeenth converter tick
          if (cyc_q == CONV_CYCLES_W - 5'h1) begin
            finish = 1'b1;
            // R8 continuous repeats, single stops
            st_d = cont_q ? ST_CONV : ST_DONE;
            cyc_d = 5'h0;
            sar_d = 8'h80;
            bit_d = 3'h7;
          end
        end
      end
      ST_DONE: begin
        st_d = ST_IDLE;
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
    // R22 write abandons and restarts; a completion on the same edge is dropped
    if (wr_scr) begin
      finish = 1'b0;
      cyc_d = 5'h0;
      sar_d = 8'h80;
      bit_d = 3'h7;
      st_d = ST_CONV;
      // R14 power-off code starts nothing
      if (i_wb_dat[CHAN_LSB +: CHAN_W] == CHAN_POWER_OFF) begin
        st_d = ST_IDLE;
      end
    end
    // R17 stop mode aborts
    if (i_stop_mode) begin
      st_d = ST_IDLE;
      finish = 1'b0;
    end
  end

  // Register file, flags and pins next values
  always_comb begin
    done_d = done_q;
    irq_en_d = irq_en_q;
    cont_d = cont_q;
    chan_d = chan_q;
    prescale_d = prescale_q;
    src_bus_d = src_bus_q;
    result_d = result_q;
    pdata_d = pdata_q;
    pdir_d = pdir_q;
    irq_d = irq_q;
    ack_d = i_wb_cyc & i_wb_stb & ~ack_q;
    rdat_d = 32'h0000_0000;
    // R10 R12 clear by write or result read
    if (wr_scr | rd_res) begin
      done_d = 1'b0;
      irq_d = 1'b0;
    end
    if (wr_scr) begin
      irq_en_d = i_wb_dat[IRQ_EN_BIT];
      cont_d = i_wb_dat[CONT_BIT];
      chan_d = i_wb_dat[CHAN_LSB +: CHAN_W];
      // R11 done bit writable under interrupt enable
      if (i_wb_dat[IRQ_EN_BIT]) begin
        done_d = i_wb_dat[DONE_BIT];
      end
    end
    if (bus_wr && i_wb_adr == ADDR_CLOCK_CONTROL) begin
      prescale_d = i_wb_dat[PRESCALE_LSB +: 3];
      src_bus_d = i_wb_dat[SRC_BIT];
    end
    if (bus_wr && i_wb_adr == ADDR_PORT_DATA) pdata_d[PIN_W-1:0] = i_wb_dat[PIN_W-1:0];
    if (bus_wr && i_wb_adr == ADDR_PORT_DIR) pdir_d[PIN_W-1:0] = i_wb_dat[PIN_W-1:0];
    if (bus_wr && i_wb_adr == ADDR_PORT_DATA_HI) pdata_d[2*PIN_W-1:PIN_W] = i_wb_dat[PIN_W-1:0];
    if (bus_wr && i_wb_adr == ADDR_PORT_DIR_HI) pdir_d[2*PIN_W-1:PIN_W] = i_wb_dat[PIN_W-1:0];
    if (finish) begin
      // R1 R7 result stored, overwriting; R6 code is the resolved trial
      result_d = sar_q;
      // R21 unused codes unchecked; last bit already settled on tick eight
      // R9 R10 set wins over clear
      if (!irq_en_q) begin
        done_d = 1'b1;
      end
      // R12 interrupt per completion, set wins
      if (irq_en_q) begin
        irq_d = 1'b1;
      end
    end
    if (bus_rd) begin
      unique case (i_wb_adr)
        ADDR_STATUS_CONTROL: rdat_d[7:0] = {done_q, irq_en_q, cont_q, chan_q};
        ADDR_RESULT: rdat_d[7:0] = result_q;
        ADDR_CLOCK_CONTROL: rdat_d[7:0] = {prescale_q, src_bus_q, 4'h0};
        ADDR_PORT_DATA: rdat_d[PIN_W-1:0] = pdata_q[PIN_W-1:0];
        ADDR_PORT_DIR: rdat_d[PIN_W-1:0] = pdir_q[PIN_W-1:0];
        ADDR_PORT_PINS: rdat_d[PIN_W-1:0] = pin_read[PIN_W-1:0];
        ADDR_PORT_DATA_HI: rdat_d[PIN_W-1:0] = pdata_q[2*PIN_W-1:PIN_W];
        ADDR_PORT_DIR_HI: rdat_d[PIN_W-1:0] = pdir_q[2*PIN_W-1:PIN_W];
        ADDR_PORT_PINS_HI: rdat_d[PIN_W-1:0] = pin_read[2*PIN_W-1:PIN_W];
        default: rdat_d = 32'h0000_0000;
      endcase
    end
    // R3 port logic cannot drive the taken pin
    pin_o_d = pdata_d;
    oe_n_d = ~pdir_d | chan_mask(chan_d);
    // R16 interrupt wakes from wait
    wake_d = i_wait_mode & irq_d;
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      // R13 reset values
      done_q <= 1'b0;
      irq_en_q <= 1'b0;
      cont_q <= 1'b0;
      chan_q <= CHAN_RESET;
      prescale_q <= PRESCALE_RESET;
      src_bus_q <= 1'b0;
      result_q <= 8'h00;
      pdata_q <= '0;
      pdir_q <= '0;
      irq_q <= 1'b0;
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
      st_q <= ST_IDLE;
      cyc_q <= 5'h0;
      sar_q <= 8'h80;
      bit_q <= 3'h7;
      pin_o_q <= '0;
      oe_n_q <= '1;
      wake_q <= 1'b0;
      power_q <= 1'b0;
    end else begin
      done_q <= done_d;
      irq_en_q <= irq_en_d;
      cont_q <= cont_d;
      chan_q <= chan_d;
      prescale_q <= prescale_d;
      src_bus_q <= src_bus_d;
      result_q <= result_d;
      pdata_q <= pdata_d;
      pdir_q <= pdir_d;
      irq_q <= irq_d;
      ack_q <= ack_d;
      rdat_q <= rdat_d;
      st_q <= st_d;
      cyc_q <= cyc_d;
      sar_q <= sar_d;
      bit_q <= bit_d;
      pin_o_q <= pin_o_d;
      oe_n_q <= oe_n_d;
      wake_q <= wake_d;
      power_q <= ~&chan_d;
    end
  end

  // Outputs straight from flip-flops
  assign o_wb_dat = rdat_q;
  assign o_wb_ack = ack_q;
  assign o_pin = pin_o_q;
  assign o_pin_oe_n = oe_n_q;
  // R2 mux follows the channel field
  assign o_mux_sel = chan_q;
  // R14 power off on all-ones code
  assign o_power_on = power_q;
  assign o_trial_code = sar_q;
  assign o_irq = irq_q;
  assign o_wake = wake_q;
endmodule : sar_adc_sequencer
`default_nettype wire

// >>> sar_prescaler.sv
/*
  Converter clock prescaler: makes a one-cycle enable pulse from the chosen source.
  Assumes both source enables are one-cycle pulses on i_sys_clk.
*/
`timescale 1ns/100ps
`default_nettype none
module sar_prescaler (
  input wire logic i_sys_clk, // System clock
  input wire logic i_rst, // Async reset, active high
  input wire logic i_bus_tick, // Bus clock enable
  input wire logic i_osc_tick, // Oscillator clock enable
  input wire logic i_src_bus, // 1 selects bus clock
  input wire logic [2:0] i_prescale, // Divide code
  input wire logic i_restart, // Realign divider
  output logic o_tick // Converter clock enable
);
  logic [3:0] cnt_q, cnt_d;
  logic tick_q, tick_d;
  logic src_tick;
  logic [3:0] limit;

  // Source select and divide limit
  always_comb begin
    src_tick = i_src_bus ? i_bus_tick : i_osc_tick;
    unique case (i_prescale[1:0])
      2'h0: limit = 4'h0;
      2'h1: limit = 4'h1;
      2'h2: limit = 4'h3;
      default: limit = 4'h7;
    endcase
    // R19 top bit forces sixteen
    if (i_prescale[2]) begin
      limit = 4'hF;
    end
  end

  // Count source ticks, pulse at the limit
  always_comb begin
    cnt_d = cnt_q;
    tick_d = 1'b0;
    if (i_restart) begin
      cnt_d = 4'h0;
    end else if (src_tick) begin
      if (cnt_q >= limit) begin
        cnt_d = 4'h0;
        tick_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 4'h1;
      end
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_q <= 4'h0;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign o_tick = tick_q;
endmodule : sar_prescaler
`default_nettype wire

// >>> tb.sv
/*
  Self-checking bench: registers, conversions, pins, interrupt, low power.
  Assumes the analog partner model and the bound checker.
*/
`timescale 1ns/100ps
`default_nettype none
module tb import sar_adc_pkg::*;;
  localparam logic [7:0] SC = ADDR_STATUS_CONTROL;
  localparam logic [7:0] RS = ADDR_RESULT;
  logic i_sys_clk, i_rst, i_bus_tick, i_osc_tick, i_stop_mode, i_wait_mode, i_cmp_above;
  logic i_wb_we, i_wb_cyc, i_wb_stb, o_wb_ack, o_power_on, o_irq, o_wake;
  logic [7:0] i_wb_adr, q, offset, o_trial_code;
  logic [31:0] i_wb_dat, o_wb_dat;
  logic [3:0] i_wb_sel;
  logic [15:0] i_pin, o_pin, o_pin_oe_n;
  logic [4:0] o_mux_sel;
  int errors, n_tests, cc, t;
  sar_adc_sequencer #(.PIN_W(8)) sar_adc_sequencer_inst (.i_sys_clk, .i_rst, .i_bus_tick, .i_osc_tick,
    .i_stop_mode, .i_wait_mode, .i_cmp_above, .i_wb_adr, .i_wb_dat, .i_wb_sel, .i_wb_we, .i_wb_cyc,
    .i_wb_stb, .i_pin, .o_wb_dat, .o_wb_ack, .o_pin, .o_pin_oe_n, .o_mux_sel, .o_power_on,
    .o_trial_code, .o_irq, .o_wake);
  analog_side analog_side_inst (.i_sys_clk(i_sys_clk), .i_chan(o_mux_sel), .i_power(o_power_on),
    .i_trial(o_trial_code), .i_offset(offset), .i_drive(o_pin), .i_drive_oe_n(o_pin_oe_n),
    .o_above(i_cmp_above), .o_level(i_pin));
  initial begin
    i_sys_clk = 1'b0;
    forever #25 i_sys_clk = ~i_sys_clk;
  end
  // Bus tick every 2nd cycle, oscillator every 4th, so the source choice shows
  always @(posedge i_sys_clk) begin
    cc <= cc + 1;
    i_bus_tick <= cc[0];
    i_osc_tick <= cc[1:0] == 2'b11;
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d, output logic [7:0] r);
    int n;
    n = 0;
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we <= we;
    i_wb_adr <= a;
    i_wb_dat <= {24'h0, d};
    i_wb_sel <= 4'h1;
    do begin
      @(posedge i_sys_clk);
      n++;
    end while (o_wb_ack !== 1'b1 && n < 20);
    r = o_wb_dat[7:0];
    chk(o_wb_ack, 1'b1);
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
    @(posedge i_sys_clk);
  endtask : wb
  // Start by a status write, then poll until the done bit shows
  task automatic conv(input logic [7:0] st, output int d);
    int t0;
    t0 = cc;
    wb(1'b1, SC, st, q);
    q = 8'h00;
    while (q[7] !== 1'b1 && cc - t0 < 1500) begin
      wb(1'b0, SC, 8'h00, q);
    end
    d = cc - t0;
  endtask : conv
  task automatic t_reset();
    wb(1'b0, SC, 8'h00, q);
    chk(q, 8'h1F);
    wb(1'b0, 8'h50, 8'h00, q);
    chk(q, 8'h00);
    wb(1'b1, SC, 8'h1F, q);
    repeat (100) @(posedge i_sys_clk);
    wb(1'b0, SC, 8'h00, q);
    chk(q, 8'h1F);
  endtask : t_reset
  task automatic t_clock();
    int dv;
    // one throwaway conversion after leaving power-off
    conv(8'h05, t);
    for (int c = 0; c < 9; c++) begin
      dv = (c == 8) ? 4 : 2 << ((c > 4) ? 4 : c);
      wb(1'b1, ADDR_CLOCK_CONTROL, (c < 8) ? {3'(c), 5'h10} : 8'h00, q);
      conv(8'h05, t);
      chk(t >= 16 * dv && t <= 18 * dv + 30, 1'b1);
      wb(1'b0, RS, 8'h00, q);
      chk(q, 8'h55);
    end
    wb(1'b1, ADDR_CLOCK_CONTROL, 8'h10, q);
  endtask : t_clock
  task automatic t_cont();
    conv(8'h25, t);
    offset <= 8'h03;
    repeat (150) @(posedge i_sys_clk);
    wb(1'b0, SC, 8'h00, q);
    chk(q, 8'hA5);
    wb(1'b0, RS, 8'h00, q);
    chk(q, 8'h58);
    conv(8'h05, t);
    wb(1'b0, RS, 8'h00, q);
    repeat (150) @(posedge i_sys_clk);
    wb(1'b0, SC, 8'h00, q);
    chk(q, 8'h05);
  endtask : t_cont
  task automatic t_irq();
    i_wait_mode <= 1'b1;
    wb(1'b1, SC, 8'h45, q);
    for (int n = 0; n < 300 && o_irq !== 1'b1; n++) @(posedge i_sys_clk);
    chk(o_irq, 1'b1);
    repeat (2) @(posedge i_sys_clk);
    chk(o_wake, 1'b1);
    wb(1'b0, SC, 8'h00, q);
    chk(q, 8'h45);
    wb(1'b0, RS, 8'h00, q);
    chk(o_irq, 1'b0);
    wb(1'b1, SC, 8'hC5, q);
    wb(1'b0, SC, 8'h00, q);
    chk(q, 8'hC5);
    wb(1'b1, SC, 8'h1F, q);
    i_wait_mode <= 1'b0;
  endtask : t_irq
  task automatic t_pins();
    wb(1'b1, ADDR_PORT_DIR, 8'hFF, q);
    wb(1'b1, ADDR_PORT_DATA, 8'hFB, q);
    wb(1'b1, SC, 8'h02, q);
    repeat (4) @(posedge i_sys_clk);
    chk(o_pin_oe_n, 16'hFF04);
    chk(o_pin, 16'h00FB);
    wb(1'b0, ADDR_PORT_PINS, 8'h00, q);
    chk(q, 8'hFB);
    wb(1'b1, ADDR_PORT_DIR, 8'hFB, q);
    wb(1'b1, ADDR_PORT_DATA, 8'hFF, q);
    repeat (4) @(posedge i_sys_clk);
    chk(o_pin_oe_n, 16'hFF04);
    wb(1'b0, ADDR_PORT_PINS, 8'h00, q);
    chk(q, 8'hFB);
  endtask : t_pins
  task automatic t_stop();
    wb(1'b1, ADDR_CLOCK_CONTROL, 8'hF0, q);
    wb(1'b1, SC, 8'h05, q);
    repeat (100) @(posedge i_sys_clk);
    i_stop_mode <= 1'b1;
    repeat (700) @(posedge i_sys_clk);
    wb(1'b0, SC, 8'h00, q);
    chk(q, 8'h05);
    i_stop_mode <= 1'b0;
    wb(1'b1, ADDR_CLOCK_CONTROL, 8'h10, q);
    repeat (70) @(posedge i_sys_clk);
    wb(1'b1, SC, 8'h0A, q);
    repeat (10) @(posedge i_sys_clk);
    conv(8'h05, t);
    chk(t >= 32 && t <= 66, 1'b1);
    wb(1'b0, RS, 8'h00, q);
    chk(q, 8'h58);
  endtask : t_stop
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : complete_run
  // Hang guard, well beyond the few thousand cycles the run needs
  initial begin
    repeat (20000) @(posedge i_sys_clk);
    errors++;
    complete_run();
  end
  initial begin
    {errors, n_tests, offset} = '0;
    {i_stop_mode, i_wait_mode, i_wb_we, i_wb_cyc, i_wb_stb} = '0;
    {i_wb_adr, i_wb_dat, i_wb_sel} = '0;
    i_rst = 1'b1;
    repeat (20) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    @(posedge i_sys_clk);
    t_reset();
    t_clock();
    t_cont();
    t_irq();
    t_pins();
    t_stop();
    complete_run();
  end
endmodule : tb
`default_nettype wire
